//--- rtl/lct_pkg.sv
/*
  Package for the line clock and tick timer unit: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package lct_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV_A = 8'h04;
  localparam logic [7:0] OFS_DIV_B = 8'h08;
  localparam logic [7:0] OFS_TICK_N = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_TICK_CNT = 8'h18;

  // Control register fields.
  localparam int CTRL_ROUTE_A = 0;
  localparam int CTRL_ROUTE_B = 1;
  localparam int CTRL_PERIODIC = 2;
  localparam int CTRL_BCD_A = 3;
  localparam int CTRL_BCD_B = 4;
  localparam int CTRL_BCD_T = 5;
  localparam int CTRL_TICK_IE = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // Status and mask fields.
  localparam int ST_TICK_REQ = 0;
  localparam int ST_TICK_RAW = 1;
  localparam int ST_W = 2;
  localparam logic [ST_W-1:0] MASK_RST = 2'h0;

  // Divide ratio limits.
  localparam logic [15:0] RATIO_BIN_MAX = 16'h8000;
  localparam logic [15:0] RATIO_BCD_MAX = 16'h2710;

  // Tick interrupt identity towards the processor.
  localparam logic [8:0] TICK_VECTOR = 9'h058;
  localparam logic [2:0] TICK_LEVEL = 3'h5;

  // Timing.
  localparam int CLK_KHZ = 100000;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int LC_IN_KHZ = 6912;
  localparam int TICK_BASE_PS = 18500000;
  localparam int TICK_BASE_CYC = TICK_BASE_PS / CLK_PERIOD_PS;
endpackage : lct_pkg

//--- rtl/lct_top.sv
/*
  Line clock and tick timer unit: two line-clock dividers fed from a
  6912 kHz rate derived inside the block, and a tick timer with one-shot
  and periodic modes, all programmed over an APB slave port.
  Assumes a single 100 MHz clock, an active-low asynchronous reset and
  an APB master that holds each request until pready.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module lct_top #(
  parameter bit TWO_CHANNEL = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic tick_req,
  output logic [8:0] tick_vector,
  output logic [2:0] tick_level,
  output logic ckt113_a,
  output logic ckt113_b,
  output logic txc_a,
  output logic rxc_a,
  output logic txc_b,
  output logic rxc_b
);
  import lct_pkg::*;

  // The prescaler holds an 11-bit count and the accumulator a 17-bit sum
  // that yields at most one enable per clock; a package that breaks
  // either limit would mis-time the outputs it feeds, so it is refused here.
  if (TICK_BASE_CYC < 2 || TICK_BASE_CYC > 2048) begin : g_bad_base
    $error("tick base period does not fit the prescaler");
  end
  if (LC_IN_KHZ < 1 || LC_IN_KHZ >= CLK_KHZ
      || CLK_KHZ >= 131072) begin : g_bad_rate
    $error("line clock input rate does not suit the accumulator");
  end

  // Effective ratio from a register field; a zero field selects the top.
  // A BCD field with a nibble above nine converts arithmetically and is
  // clamped to the top only if the sum exceeds 10000, so a careless value still gives a running divider.
  function automatic logic [15:0] eff_ratio(input logic [15:0] v,
                                            input logic bcd);
    logic [15:0] b;
    b = 16'(v[15:12]) * 16'd1000 + 16'(v[11:8]) * 16'd100
        + 16'(v[7:4]) * 16'd10 + 16'(v[3:0]);
    if (bcd) begin
      eff_ratio = (v == 16'h0000 || b > RATIO_BCD_MAX) ? RATIO_BCD_MAX : b;
    end else begin
      eff_ratio = (v == 16'h0000 || v > RATIO_BIN_MAX) ? RATIO_BIN_MAX : v;
    end
  endfunction : eff_ratio

  // Bus decode.
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_div_a = (paddr == OFS_DIV_A);
  wire hit_div_b = (paddr == OFS_DIV_B);
  wire hit_tick_n = (paddr == OFS_TICK_N);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_mask = (paddr == OFS_MASK);
  wire hit_cnt = (paddr == OFS_TICK_CNT);
  wire mapped = hit_ctrl | hit_div_a | hit_div_b | hit_tick_n
                | hit_status | hit_mask | hit_cnt;

  // Every register answers in its access cycle, so no wait state is ever
  // inserted. An unmapped or unaligned offset is refused with pslverr: a
  // write there changes nothing and a read returns zero.
  assign pready = penable;
  assign pslverr = psel && penable && !mapped;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [15:0] div_a_reg;
  logic [15:0] div_b_reg;
  logic [15:0] tick_n_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [31:0] prdata_reg;
  logic [16:0] tick_cnt_reg;

  wire tick_ie = ctrl_reg[CTRL_TICK_IE];

  // Writes land only at the access edge. The ratio and interval fields
  // keep the raw value written, and the effective ratio is formed where
  // it is used, so a read returns exactly what software wrote and a
  // field of zero still selects the longest count.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RST;
      div_a_reg <= 16'h0000;
      div_b_reg <= 16'h0000;
      tick_n_reg <= 16'h0000;
      mask_reg <= MASK_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_reg <= pwdata[CTRL_W-1:0];
      if (hit_div_a) div_a_reg <= pwdata[15:0];
      if (hit_div_b) div_b_reg <= pwdata[15:0];
      if (hit_tick_n) tick_n_reg <= pwdata[15:0];
      if (hit_mask) mask_reg <= pwdata[ST_W-1:0];
    end
  end

  // Read data is captured in the setup cycle so it stands from a flop.
  wire [31:0] rd_mux =
    hit_ctrl ? {25'h0, ctrl_reg} :
    hit_div_a ? {16'h0, div_a_reg} :
    hit_div_b ? {16'h0, div_b_reg} :
    hit_tick_n ? {16'h0, tick_n_reg} :
    hit_status ? {30'h0, status_reg} :
    hit_mask ? {30'h0, mask_reg} :
    hit_cnt ? {15'h0, tick_cnt_reg} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;

  // Shared 6912 kHz enable from a phase accumulator; the average rate is
  // exact, at the cost of one system clock of jitter per edge.
  localparam logic [16:0] ACC_STEP = 17'(LC_IN_KHZ);
  localparam logic [16:0] ACC_MOD = 17'(CLK_KHZ);
  logic [16:0] acc_reg;
  wire [17:0] acc_sum = {1'b0, acc_reg} + {1'b0, ACC_STEP};
  wire lc_tick = (acc_sum >= {1'b0, ACC_MOD});
  wire [17:0] acc_wrap = acc_sum - {1'b0, ACC_MOD};
  wire [16:0] acc_next = lc_tick ? acc_wrap[16:0] : acc_sum[16:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) acc_reg <= 17'h00000;
    else acc_reg <= acc_next;
  end

  // Line-clock dividers, generated for both channels.
  wire [1:0] lc_load = {wr_en && hit_div_b && TWO_CHANNEL,
                        wr_en && hit_div_a};
  wire [15:0] lc_ratio [2];
  assign lc_ratio[0] = eff_ratio(div_a_reg, ctrl_reg[CTRL_BCD_A]);
  assign lc_ratio[1] = eff_ratio(div_b_reg, ctrl_reg[CTRL_BCD_B]);
  logic [1:0] lc_out;

  // A ratio of one leaves the output steadily high: the shared rate is an
  // enable, not a clock, so it cannot be passed straight through. A
  // channel toggles only once its own ratio has been written, which keeps
  // an unused circuit 113 line quiet after reset.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lc
      logic armed_reg;
      logic [15:0] cnt_reg;
      logic out_reg;
      // The counter stays idle until firmware first loads a ratio.
      wire [15:0] half = lc_ratio[g] >> 1;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          armed_reg <= 1'b0;
          cnt_reg <= 16'h0000;
          out_reg <= 1'b0;
        end else if (lc_load[g]) begin
          armed_reg <= 1'b1;
          cnt_reg <= 16'h0000;
        end else if (armed_reg && lc_tick) begin
          cnt_reg <= (cnt_reg + 16'd1 >= lc_ratio[g]) ? 16'h0000 :
                     cnt_reg + 16'd1;
          out_reg <= (lc_ratio[g] == 16'd1) ? 1'b1 : (cnt_reg < half);
        end
      end
      assign lc_out[g] = out_reg;
    end
  endgenerate

  // Output stage: 113 always carries the clock, serial inputs only when
  // routed.
  // The extra flop keeps every clock output free of decode glitches, at
  // the cost of one cycle of delay against the divider. Channel B stays
  // low on the single-channel build because it has no destination there.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ckt113_a <= 1'b0;
      ckt113_b <= 1'b0;
      txc_a <= 1'b0;
      rxc_a <= 1'b0;
      txc_b <= 1'b0;
      rxc_b <= 1'b0;
    end else begin
      ckt113_a <= lc_out[0];
      ckt113_b <= lc_out[1] && TWO_CHANNEL;
      txc_a <= lc_out[0] && ctrl_reg[CTRL_ROUTE_A];
      rxc_a <= lc_out[0] && ctrl_reg[CTRL_ROUTE_A];
      txc_b <= lc_out[1] && ctrl_reg[CTRL_ROUTE_B] && TWO_CHANNEL;
      rxc_b <= lc_out[1] && ctrl_reg[CTRL_ROUTE_B] && TWO_CHANNEL;
    end
  end

  // Tick timer: an 18.5 us base prescaler and a count of N plus one bases.
  // Writing the interval restarts the count at once in either mode. A mode
  // change while running is taken at the next terminal count, so switching
  // to one-shot never cuts a period short.
  typedef enum logic [1:0] {TS_IDLE, TS_RUN} lct_tick_state_t;
  lct_tick_state_t tstate_reg;
  logic [10:0] pre_reg;
  localparam logic [10:0] PRE_LAST = 11'(TICK_BASE_CYC - 1);
  wire tick_load = wr_en && hit_tick_n;
  wire [16:0] tick_span =
    {1'b0, eff_ratio(tick_n_reg, ctrl_reg[CTRL_BCD_T])} + 17'd1;
  wire base_end = (pre_reg == PRE_LAST);
  // The event falls on the last prescaler cycle of the final base period.
  wire tick_end = (tstate_reg == TS_RUN) && base_end
                  && (tick_cnt_reg == 17'd1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tstate_reg <= TS_IDLE;
      pre_reg <= 11'h000;
      tick_cnt_reg <= 17'h00000;
    end else if (tick_load) begin
      tstate_reg <= TS_RUN;
      pre_reg <= 11'h000;
      tick_cnt_reg <= 17'h00000;
    end else begin
      case (tstate_reg)
        TS_IDLE: begin
          pre_reg <= 11'h000;
        end
        TS_RUN: begin
          pre_reg <= base_end ? 11'h000 : pre_reg + 11'd1;
          if (tick_cnt_reg == 17'd0) begin
            tick_cnt_reg <= tick_span;
          end else if (tick_end) begin
            if (ctrl_reg[CTRL_PERIODIC]) begin
              tick_cnt_reg <= tick_span;
            end else begin
              tick_cnt_reg <= 17'h00000;
              tstate_reg <= TS_IDLE;
            end
          end else if (base_end) begin
            tick_cnt_reg <= tick_cnt_reg - 17'd1;
          end
        end
        default: begin
          tstate_reg <= TS_IDLE;
        end
      endcase
    end
  end

  // The first base period after a load also absorbs the reload cycle, so
  // the load cycle is not lost from the interval.
  // A tick that lands on a clearing write still sets its bit, so no event
  // is lost to the acknowledge. Clearing the enable drops the pending
  // request at the next edge, and tick_req is gated by the bit as well so
  // the request falls right after the write.
  wire st_clr_wr = wr_en && hit_status;
  wire [ST_W-1:0] st_set = {tick_end, tick_end && tick_ie};
  logic [ST_W-1:0] st_next;
  always_comb begin
    st_next = status_reg & ~(st_clr_wr ? pwdata[ST_W-1:0] : {ST_W{1'b0}});
    if (!tick_ie) begin
      st_next[ST_TICK_REQ] = 1'b0;
    end
    st_next = st_next | st_set;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) status_reg <= {ST_W{1'b0}};
    else status_reg <= st_next;
  end

  assign tick_req = status_reg[ST_TICK_REQ] && tick_ie;
  assign tick_vector = TICK_VECTOR;
  assign tick_level = TICK_LEVEL;
  // Only the unmasked status bits drive irq; the mask leaves tick_req
  // alone, since that line goes to the processor's own priority logic.
  assign irq = |(status_reg & mask_reg);
endmodule : lct_top

//--- sim/lct_props.sv
/*
  Checker for the line clock and tick timer unit, bound into lct_top.
  Assumes it sees only the top module's ports, all in one clock domain.
*/
`timescale 1ns/1ps
module lct_props #(
  parameter bit TWO_CHANNEL = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tick_req,
  input wire logic [8:0] tick_vector,
  input wire logic [2:0] tick_level,
  input wire logic ckt113_a,
  input wire logic ckt113_b,
  input wire logic txc_a,
  input wire logic rxc_a,
  input wire logic txc_b,
  input wire logic rxc_b
);
  import lct_pkg::*;
  wire apb_wr = psel && penable && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_tick_ident: assert property (tick_vector == TICK_VECTOR &&
    tick_level == TICK_LEVEL) else $error("tick identity wrong");
  a_ready_zero: assert property (pready == penable)
    else $error("pready not zero wait");
  a_bad_addr: assert property (psel && penable && paddr > OFS_TICK_CNT
    |-> pslverr) else $error("unmapped access not flagged");
  a_good_addr: assert property (psel && penable && paddr[1:0] == 2'h0
    && paddr <= OFS_TICK_CNT |-> !pslverr) else $error("false slave error");
  a_route_a: assert property (txc_a |-> ckt113_a)
    else $error("line clock A routed but not on 113");
  a_route_b: assert property (txc_b |-> ckt113_b)
    else $error("line clock B routed but not on 113");
  a_rx_tx: assert property (rxc_a == txc_a && rxc_b == txc_b)
    else $error("receive and transmit clocks differ");
  a_one_chan: assert property (!TWO_CHANNEL |-> !txc_b && !rxc_b)
    else $error("channel B clock on single channel");
  a_req_drop: assert property ($fell(tick_req) |-> $past(apb_wr))
    else $error("tick request dropped without a write");
  cover property ($rose(tick_req));
  cover property ($rose(txc_b));
  cover property (pslverr);
endmodule : lct_props
bind lct_top lct_props #(.TWO_CHANNEL(TWO_CHANNEL)) i_lct_props (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .tick_req(tick_req), .tick_vector(tick_vector),
  .tick_level(tick_level), .ckt113_a(ckt113_a), .ckt113_b(ckt113_b),
  .txc_a(txc_a), .rxc_a(rxc_a), .txc_b(txc_b), .rxc_b(rxc_b));

//--- sim/lct_slc_model.sv
/*
  Serial line controller clock input model: counts line clock edges.
  Assumes txc and rxc are sampled on the system clock.
*/
`timescale 1ns/1ps
module lct_slc_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic txc,
  input wire logic rxc,
  output int edges,
  output int skew
);
  logic txc_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txc_reg <= 1'b0;
      edges <= 0;
      skew <= 0;
    end else begin
      txc_reg <= txc;
      edges <= edges + int'(txc && !txc_reg);
      skew <= skew + int'(rxc !== txc);
    end
  end
endmodule : lct_slc_model

//--- sim/line_clock_and_tick_timer_tb.sv
/*
  Self-checking bench for lct_top: register rows, line clocks, tick timer.
  Assumes a 100 MHz clock and the zero-wait APB slave of lct_top.
*/
`timescale 1ns/1ps
module line_clock_and_tick_timer_tb;
  import lct_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, x;
    logic e;} lct_row_t;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irq, tick_req, ckt113_a, ckt113_b, e;
  logic txc_a, rxc_a, txc_b, rxc_b;
  logic [8:0] tick_vector;
  logic [2:0] tick_level;
  int err_total = 0, samples_checked = 0, n, ea, eb, sa, sb, a0, b0;
  int ec, sc, c0;
  lct_row_t rows [9] = '{'{0, OFS_CTRL, 0, 0, 0}, '{0, OFS_MASK, 0, 0, 0},
    '{0, OFS_STATUS, 0, 0, 0}, '{1, OFS_CTRL, 32'hffff_ffbf, 0, 0},
    '{0, OFS_CTRL, 0, 32'h3f, 0}, '{1, OFS_MASK, 32'hffff_ffff, 0, 0},
    '{0, OFS_MASK, 0, 32'h3, 0}, '{1, 8'h1c, 32'h1, 0, 1},
    '{0, 8'h1c, 0, 0, 1}};
  lct_top #(.TWO_CHANNEL(1'b1)) i_lct_top (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tick_req(tick_req), .tick_vector(tick_vector),
    .tick_level(tick_level), .ckt113_a(ckt113_a), .ckt113_b(ckt113_b),
    .txc_a(txc_a), .rxc_a(rxc_a), .txc_b(txc_b), .rxc_b(rxc_b));
  lct_slc_model i_slc_a (.clk(clk), .rstn(rstn), .txc(txc_a), .rxc(rxc_a),
    .edges(ea), .skew(sa));
  lct_slc_model i_slc_b (.clk(clk), .rstn(rstn), .txc(txc_b), .rxc(rxc_b),
    .edges(eb), .skew(sb));
  lct_slc_model i_slc_c (.clk(clk), .rstn(rstn), .txc(ckt113_a),
    .rxc(ckt113_a), .edges(ec), .skew(sc));
  initial begin
    forever #5 clk = ~clk;
  end
  task test_done;
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // Ends one idle cycle after the access so psel is never driven twice.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(pready, 1, "no bus answer");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wait_req(output int c);
    c = 0;
    while (tick_req !== 1'b1 && c < 5000) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_req
  initial begin
    #500000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    chk({txc_a, ckt113_a, irq, tick_req}, 0, "outputs busy in reset");
    rstn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].x, "register read");
      chk(e, rows[i].e, "slave error flag");
    end
    apb(1, OFS_CTRL, 32'h13);
    apb(1, OFS_DIV_A, 32'h2);
    repeat (2000) @(posedge clk);
    chk({ckt113_b, txc_b}, 0, "unloaded counter toggles");
    chk(eb, 0, "unloaded counter gave edges");
    apb(1, OFS_DIV_B, 32'h10);
    a0 = ea;
    b0 = eb;
    repeat (2000) @(posedge clk);
    chk(ea - a0 inside {[68:70]}, 1, "line clock A rate");
    chk(eb - b0 inside {[13:15]}, 1, "line clock B bcd rate");
    chk(sa + sb + sc, 0, "serial clocks differ");
    apb(1, OFS_MASK, 32'h1);
    apb(1, OFS_CTRL, 32'h40);
    c0 = ec;
    apb(1, OFS_TICK_N, 32'h1);
    wait_req(n);
    chk(n inside {[3698:3704]}, 1, "one-shot interval");
    chk(irq, 1, "interrupt not raised");
    chk(ec - c0 inside {[120:135]}, 1, "113 idle when unrouted");
    chk(txc_a, 0, "unrouted clock reaches serial input");
    apb(1, OFS_CTRL, 32'h0);
    chk(tick_req, 0, "request kept after disable");
    apb(0, OFS_STATUS, 0);
    chk(q, 32'h2, "pending bit kept");
    apb(1, OFS_STATUS, 32'h3);
    apb(1, OFS_CTRL, 32'h40);
    wait_req(n);
    chk(n, 5000, "one-shot ticked twice");
    apb(1, OFS_CTRL, 32'h44);
    apb(1, OFS_TICK_N, 32'h1);
    wait_req(n);
    chk(n inside {[3698:3704]}, 1, "periodic first tick");
    apb(1, OFS_CTRL, 32'h04);
    apb(1, OFS_CTRL, 32'h44);
    wait_req(n);
    chk(n + 6 inside {[3697:3703]}, 1, "periodic spacing");
    apb(1, OFS_MASK, 32'h0);
    chk({irq, tick_req}, 2'h1, "mask ignored");
    apb(1, OFS_STATUS, 32'h3);
    chk(tick_req, 0, "status clear ignored");
    test_done();
  end
endmodule : line_clock_and_tick_timer_tb
